// ===== verilog/vfdph_pkg.sv
// package of constants and the strobe edge finder for the display parallel host port
`timescale 1ns/1ps
package vfdph_pkg;
	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int unsigned BUS_W  = 8;          // full byte on the bus lines
	localparam int unsigned NIB_W  = 4;          // one nibble on the upper bus lines
	localparam int unsigned AC_W   = 7;          // address counter image width
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] OFS_STATUS  = 4'h0;   // status, write one to clear the overrun and read done bits
	localparam logic [3:0] OFS_RXDATA  = 4'h4;   // last byte from host, read pops it
	localparam logic [3:0] OFS_TXDATA  = 4'h8;   // byte returned on data reads
	localparam logic [3:0] OFS_ADDRCNT = 4'hC;   // counter image returned on instruction reads
	// ----------------------------------------
	// status bit positions
	// ----------------------------------------
	localparam int unsigned ST_RX_VALID   = 0;
	localparam int unsigned ST_RX_IS_DATA = 1;
	localparam int unsigned ST_OVERRUN    = 2;
	localparam int unsigned ST_RD_DONE    = 3;
	localparam int unsigned ST_MODE_SEP   = 4;
	localparam int unsigned ST_NIBBLE     = 5;
	localparam int unsigned ST_PHASE      = 6;
	// ----------------------------------------
	// reset values and fixed answers
	// ----------------------------------------
	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [6:0] RST_AC     = 7'h00;
	localparam logic       BUSY_READ  = 1'b0;    // commands are buffered, never busy
	localparam logic [3:0] NIB_PAD    = 4'h0;    // lower lines during nibble reads
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage : vfdph_pkg

// rise and fall pulses of one synchronous strobe
module vfdph_edge #(
	parameter logic IDLE = 1'b0               // level the strobe rests at
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic level_i,
	output logic      rise_o,
	output logic      fall_o
);
	logic prev_reg;                           // level one cycle ago

	// ----------------------------------------
	// history
	// ----------------------------------------
	// reset to the idle level so release of reset fakes no edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prev_reg <= IDLE;
		end else begin
			prev_reg <= level_i;
		end
	end

	assign rise_o = level_i & ~prev_reg;
	assign fall_o = ~level_i & prev_reg;
endmodule : vfdph_edge

// ===== verilog/vfdph_port.sv
// parallel host port of the character display: strobes, nibble pairing, wishbone registers
`timescale 1ns/1ps

module vfdph_port (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// host pins
	input  wire logic        cmd_data_select_i,  // low instruction, high data
	input  wire logic        rnw_i,              // single enable: high read
	input  wire logic        enable_i,           // single enable strobe
	input  wire logic        rd_n_i,             // separate read strobe
	input  wire logic        wr_n_i,             // separate write strobe
	input  wire logic [7:0]  bus_lines_i,
	output logic      [7:0]  bus_lines_o,
	output logic             bus_lines_oe_o,
	// jumpers
	input  wire logic        jmp_sep_strobe_i,   // high: separate read/write strobes
	input  wire logic        jmp_nibble_i,       // high: 4-bit bus
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	logic       cfg_taken_reg;     // jumpers sampled
	logic       mode_sep_reg;      // separate strobe style
	logic       nibble_reg;        // 4-bit width
	logic       phase_reg;         // high: lower nibble next
	logic [3:0] hi_reg;            // upper nibble held for pairing
	logic [7:0] rx_data_reg;       // byte from host
	logic       rx_is_data_reg;    // byte was data
	logic       rx_valid_reg;      // byte waits for software
	logic       overrun_reg;       // byte lost
	logic       rd_done_reg;       // host took a data byte
	logic [7:0] rd_byte_reg;       // byte being read by host
	logic [7:0] tx_reg;            // data read answer
	logic [6:0] ac_reg;            // instruction read answer
	logic [7:0] bus_o_reg;
	logic       oe_reg;
	logic [31:0] dat_o_reg;
	logic       ack_reg;

	// ----------------------------------------
	// strobe edges
	// ----------------------------------------
	logic e_rise, e_fall, wrn_rise, rdn_rise, rdn_fall;

	vfdph_edge #(.IDLE(1'b0)) u_en (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.level_i (enable_i),
		.rise_o  (e_rise),
		.fall_o  (e_fall)
	);
	vfdph_edge #(.IDLE(1'b1)) u_wr (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.level_i (wr_n_i),
		.rise_o  (wrn_rise),
		.fall_o  ()
	);
	vfdph_edge #(.IDLE(1'b1)) u_rd (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.level_i (rd_n_i),
		.rise_o  (rdn_rise),
		.fall_o  (rdn_fall)
	);

	// picks the nibble of a byte that the current phase carries
	function automatic logic [7:0] nib_lane(input logic [7:0] b, input logic lower);
		nib_lane = lower ? {b[3:0], vfdph_pkg::NIB_PAD} : {b[7:4], vfdph_pkg::NIB_PAD};
	endfunction : nib_lane

	// ----------------------------------------
	// transfer decode
	// ----------------------------------------
	logic wr_evt, rd_start, rd_end, rd_active, first, complete;
	logic [7:0] wr_byte, fresh_byte, sel_byte;
	logic wb_hit, sw_pop, sw_clr_ovr, sw_clr_done;

	assign wr_evt    = mode_sep_reg ? wrn_rise : (e_fall & ~rnw_i);
	assign rd_start  = mode_sep_reg ? rdn_fall : (e_rise & rnw_i);
	assign rd_end    = mode_sep_reg ? rdn_rise : (e_fall & rnw_i);
	assign rd_active = mode_sep_reg ? ~rd_n_i : (enable_i & rnw_i);
	assign first     = ~nibble_reg | ~phase_reg;
	assign complete  = ~nibble_reg | phase_reg;
	// nibble mode ignores the lower lines entirely
	assign wr_byte   = nibble_reg ? {hi_reg, bus_lines_i[7:4]} : bus_lines_i;
	assign fresh_byte = cmd_data_select_i ? tx_reg : {vfdph_pkg::BUSY_READ, ac_reg};
	assign sel_byte  = (rd_start & first) ? fresh_byte : rd_byte_reg;

	assign wb_hit      = wb_cyc_i & wb_stb_i & ack_reg;
	assign sw_pop      = wb_hit & ~wb_we_i & (wb_adr_i == vfdph_pkg::OFS_RXDATA);
	assign sw_clr_ovr  = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == vfdph_pkg::OFS_STATUS)
	                     & wb_dat_i[vfdph_pkg::ST_OVERRUN];
	assign sw_clr_done = wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == vfdph_pkg::OFS_STATUS)
	                     & wb_dat_i[vfdph_pkg::ST_RD_DONE];

	// ----------------------------------------
	// jumper capture
	// ----------------------------------------
	// taken once after reset release; later jumper motion has no effect
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_taken_reg <= 1'b0;
			mode_sep_reg  <= 1'b0;
			nibble_reg    <= 1'b0;
		end else if (!cfg_taken_reg) begin
			cfg_taken_reg <= 1'b1;
			mode_sep_reg  <= jmp_sep_strobe_i;
			nibble_reg    <= jmp_nibble_i;
		end
	end

	// ----------------------------------------
	// nibble phase
	// ----------------------------------------
	// one toggle shared by reads and writes, so every strobe pair is one byte
	always_ff @(posedge clk_i) begin
		if (rst_i || !nibble_reg) begin
			phase_reg <= 1'b0;
		end else if (wr_evt || rd_end) begin
			phase_reg <= ~phase_reg;
		end
	end

	// ----------------------------------------
	// write path
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hi_reg         <= vfdph_pkg::NIB_PAD;
			rx_data_reg    <= vfdph_pkg::RST_BYTE;
			rx_is_data_reg <= 1'b0;
		end else if (wr_evt) begin
			if (!complete) begin
				hi_reg <= bus_lines_i[7:4];
			end else begin
				rx_data_reg    <= wr_byte;
				rx_is_data_reg <= cmd_data_select_i;
			end
		end
	end

	// sticky flags: a hardware set in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_valid_reg <= 1'b0;
			overrun_reg  <= 1'b0;
			rd_done_reg  <= 1'b0;
		end else begin
			if (wr_evt && complete) begin
				rx_valid_reg <= 1'b1;
			end else if (sw_pop) begin
				rx_valid_reg <= 1'b0;
			end
			if (wr_evt && complete && rx_valid_reg && !sw_pop) begin
				overrun_reg <= 1'b1;
			end else if (sw_clr_ovr) begin
				overrun_reg <= 1'b0;
			end
			if (rd_end && complete && cmd_data_select_i) begin
				rd_done_reg <= 1'b1;
			end else if (sw_clr_done) begin
				rd_done_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	// the byte is frozen at the first strobe so both nibbles come from one value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_byte_reg <= vfdph_pkg::RST_BYTE;
			bus_o_reg   <= vfdph_pkg::RST_BYTE;
		end else if (rd_start) begin
			rd_byte_reg <= sel_byte;
			bus_o_reg   <= nibble_reg ? nib_lane(sel_byte, phase_reg) : sel_byte;
		end
	end

	// enable follows the strobe with one register of lag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			oe_reg <= 1'b0;
		end else begin
			oe_reg <= rd_active;
		end
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	// ack one cycle after the request, writes commit on the acked edge
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg   <= 1'b0;
			dat_o_reg <= vfdph_pkg::WORD_ZERO;
		end else begin
			ack_reg   <= wb_cyc_i & wb_stb_i & ~ack_reg;
			dat_o_reg <= vfdph_pkg::WORD_ZERO;
			case (wb_adr_i)
				vfdph_pkg::OFS_STATUS: begin
					dat_o_reg[vfdph_pkg::ST_RX_VALID]   <= rx_valid_reg;
					dat_o_reg[vfdph_pkg::ST_RX_IS_DATA] <= rx_is_data_reg;
					dat_o_reg[vfdph_pkg::ST_OVERRUN]    <= overrun_reg;
					dat_o_reg[vfdph_pkg::ST_RD_DONE]    <= rd_done_reg;
					dat_o_reg[vfdph_pkg::ST_MODE_SEP]   <= mode_sep_reg;
					dat_o_reg[vfdph_pkg::ST_NIBBLE]     <= nibble_reg;
					dat_o_reg[vfdph_pkg::ST_PHASE]      <= phase_reg;
				end
				vfdph_pkg::OFS_RXDATA:  dat_o_reg[7:0] <= rx_data_reg;
				vfdph_pkg::OFS_TXDATA:  dat_o_reg[7:0] <= tx_reg;
				vfdph_pkg::OFS_ADDRCNT: dat_o_reg[6:0] <= ac_reg;
				default:                dat_o_reg <= vfdph_pkg::WORD_ZERO; // unmapped reads zero
			endcase
		end
	end

	// software answer registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_reg <= vfdph_pkg::RST_BYTE;
			ac_reg <= vfdph_pkg::RST_AC;
		end else if (wb_hit && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == vfdph_pkg::OFS_TXDATA) begin
				tx_reg <= wb_dat_i[7:0];
			end
			if (wb_adr_i == vfdph_pkg::OFS_ADDRCNT) begin
				ac_reg <= wb_dat_i[6:0];
			end
		end
	end

	assign bus_lines_o    = bus_o_reg;
	assign bus_lines_oe_o = oe_reg;
	assign wb_dat_o       = dat_o_reg;
	assign wb_ack_o       = ack_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	cfg_static_a: assert property (cfg_taken_reg
		|=> $stable(mode_sep_reg) && $stable(nibble_reg))
		else $error("port style changed during operation");
	busy_zero_a: assert property (rd_start && first && !cmd_data_select_i |=> !rd_byte_reg[7])
		else $error("busy indication read as one");
	oe_only_read_a: assert property (bus_lines_oe_o |-> $past(rd_active))
		else $error("bus driven outside a read");
	byte_write_a: assert property (wr_evt && !nibble_reg |=> rx_data_reg == $past(bus_lines_i))
		else $error("byte write not captured");
	// the completing strobe joins the held upper nibble with the current upper lines
	nibble_pair_a: assert property (wr_evt && nibble_reg && phase_reg
		|=> rx_data_reg == {$past(hi_reg), $past(bus_lines_i[7:4])} && !phase_reg)
		else $error("nibble pair misassembled");
	phase_idle_a: assert property (!nibble_reg |=> !phase_reg)
		else $error("phase moved in byte mode");
	enable_write_a: assert property (!mode_sep_reg && e_fall && !rnw_i && !nibble_reg
		|=> rx_valid_reg)
		else $error("enable fall write lost");
	strobe_write_a: assert property (mode_sep_reg && wrn_rise && !nibble_reg |=> rx_valid_reg)
		else $error("write strobe rise lost");
	route_sel_a: assert property (wr_evt && complete
		|=> rx_is_data_reg == $past(cmd_data_select_i))
		else $error("select line not routed");
	enable_read_a: assert property (!mode_sep_reg && e_rise && rnw_i |=> bus_lines_oe_o)
		else $error("no drive after enable rise");
	strobe_read_a: assert property (mode_sep_reg && rdn_fall |=> bus_lines_oe_o)
		else $error("no drive after read strobe fall");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
endmodule : vfdph_port

// ===== bench/vfdph_host_model.sv
// host side model of the display parallel port: strobes, nibble split, pulled-up bus
`timescale 1ns/1ps
module vfdph_host_model (
	input  wire logic       clk_i,
	input  wire logic       sep_i,             // high: separate read/write strobes
	input  wire logic       nib_i,             // high: 4-bit bus
	input  wire logic [7:0] bus_lines_i,       // resolved bus level
	input  wire logic       bus_lines_oe_i,    // port drives the bus
	output logic            cmd_data_select_o,
	output logic            rnw_o,
	output logic            enable_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [7:0]      bus_lines_o
);
	logic [3:0] pad;       // lower lines seen on the last nibble read
	logic       oe_after;  // port drive enable shortly after the last strobe
	// ----------------------------------------
	// idle levels at time zero
	// ----------------------------------------
	initial begin
		cmd_data_select_o = 1'b0;
		rnw_o = 1'b0;
		enable_o = 1'b0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		bus_lines_o = 8'hFF;
	end
	// ----------------------------------------
	// one strobe, held for two clocks at least
	// ----------------------------------------
	task automatic beat(input logic rd, input logic rs, input logic [7:0] v,
		output logic [7:0] got);
		int n;
		n = 0;
		@(posedge clk_i);
		cmd_data_select_o <= rs;
		rnw_o <= rd;
		bus_lines_o <= rd ? 8'hFF : v;      // released lines read high via pull-ups
		@(posedge clk_i);
		if (!sep_i) enable_o <= 1'b1;
		else if (rd) rd_n_o <= 1'b0;
		else wr_n_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		// a slow port gets a few extra clocks before the strobe ends
		while (rd && bus_lines_oe_i !== 1'b1 && n < 8) begin
			@(posedge clk_i);
			n++;
		end
		got = bus_lines_i;
		enable_o <= 1'b0;
		rd_n_o <= 1'b1;
		wr_n_o <= 1'b1;
		@(posedge clk_i);
		bus_lines_o <= 8'hFF;               // data held one clock past the strobe
		rnw_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		oe_after = bus_lines_oe_i;
	endtask : beat
	// ----------------------------------------
	// one byte, split into nibbles if jumpered
	// ----------------------------------------
	task automatic xfer(input logic rd, input logic rs, input logic [7:0] v,
		output logic [7:0] got);
		logic [7:0] hi;
		logic [7:0] lo;
		if (nib_i) begin
			// junk on the lower lines must be ignored by the port
			beat(rd, rs, {v[7:4], ~v[7:4]}, hi);
			beat(rd, rs, {v[3:0], ~v[3:0]}, lo);
			got = {hi[7:4], lo[7:4]};
			pad = hi[3:0] | lo[3:0];
		end else begin
			beat(rd, rs, v, got);
			pad = 4'h0;
		end
	endtask : xfer
endmodule : vfdph_host_model

// ===== bench/vfd_parallel_host_port_bench.sv
// testbench of the display parallel host port in all four jumper settings
`timescale 1ns/1ps
module vfd_parallel_host_port_bench;
	logic        clk_i  = 1'b0;
	logic        rst_i  = 1'b1;
	logic        sep    = 1'b0;
	logic        nib    = 1'b0;
	logic        jsep   = 1'b0;                   // jumper pins, apart from the host's view
	logic        jnib   = 1'b0;
	logic        wb_cyc = 1'b0;
	logic        wb_stb = 1'b0;
	logic        wb_we  = 1'b0;
	logic [3:0]  wb_adr = 4'h0;
	logic [31:0] wb_dat = 32'h0000_0000;
	logic        rs, rnw, en, rd_n, wr_n, dut_oe, wb_ack;
	logic [7:0]  host_bus, dut_bus, bus_w;
	logic [31:0] wb_rdat;
	int          bad_count = 0;
	int          compares  = 0;
	always #10 clk_i = ~clk_i;
	assign bus_w = dut_oe ? dut_bus : host_bus;   // port wins while it drives
	vfdph_port uut (.clk_i(clk_i), .rst_i(rst_i), .cmd_data_select_i(rs), .rnw_i(rnw),
		.enable_i(en), .rd_n_i(rd_n), .wr_n_i(wr_n), .bus_lines_i(bus_w),
		.bus_lines_o(dut_bus), .bus_lines_oe_o(dut_oe), .jmp_sep_strobe_i(jsep),
		.jmp_nibble_i(jnib), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack));
	vfdph_host_model host (.clk_i(clk_i), .sep_i(sep), .nib_i(nib), .bus_lines_i(bus_w),
		.bus_lines_oe_i(dut_oe), .cmd_data_select_o(rs), .rnw_o(rnw), .enable_o(en),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .bus_lines_o(host_bus));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up
	// classic wishbone cycle, held until ack is sampled high
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, a, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
		r = wb_rdat;
		{wb_cyc, wb_stb, wb_we} <= 3'b000;
	endtask : wb
	// ----------------------------------------
	// one jumper setting, fresh from reset
	// ----------------------------------------
	task automatic run_mode(input logic s, input logic n);
		logic [31:0] r;
		logic [31:0] md;
		logic [7:0]  g;
		md = ({31'h0, s} << vfdph_pkg::ST_MODE_SEP) | ({31'h0, n} << vfdph_pkg::ST_NIBBLE);
		@(posedge clk_i);
		{sep, nib, jsep, jnib, rst_i} <= {s, n, s, n, 1'b1};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);                  // host holds off past reset
		// jumpers moved after capture must leave the port style alone
		{jsep, jnib} <= {~s, ~n};
		wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
		check(r, md);
		host.xfer(1'b0, 1'b1, 8'hA5, g);
		wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
		check(r, md | 32'h0000_0003);
		wb(1'b0, vfdph_pkg::OFS_RXDATA, 32'h0, r);
		check(r, 32'h0000_00A5);
		// two instructions back to back with no pop between
		host.xfer(1'b0, 1'b0, 8'h3C, g);
		host.xfer(1'b0, 1'b0, 8'h96, g);
		wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
		check(r, md | 32'h0000_0005);
		wb(1'b0, vfdph_pkg::OFS_RXDATA, 32'h0, r);
		check(r, 32'h0000_0096);
		wb(1'b1, vfdph_pkg::OFS_STATUS, 32'h0000_0004, r);
		wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
		check(r, md);
		// data read returns the transmit byte
		wb(1'b1, vfdph_pkg::OFS_TXDATA, 32'h0000_00C3, r);
		host.xfer(1'b1, 1'b1, 8'h00, g);
		check({24'h0, g}, 32'h0000_00C3);
		check({28'h0, host.pad}, 32'h0);
		check({31'h0, host.oe_after}, 32'h0);
		// the finished data read leaves its sticky flag, write one clears it
		wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
		check(r, md | 32'h0000_0008);
		wb(1'b1, vfdph_pkg::OFS_STATUS, 32'h0000_0008, r);
		wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
		check(r, md);
		// instruction read: busy bit on top, counter below
		wb(1'b1, vfdph_pkg::OFS_ADDRCNT, 32'h0000_007F, r);
		host.xfer(1'b1, 1'b0, 8'h00, g);
		check({24'h0, g}, 32'h0000_007F);
		// unmapped place reads zero and ignores writes
		wb(1'b1, 4'h2, 32'hFFFF_FFFF, r);
		wb(1'b0, 4'h2, 32'h0, r);
		check(r, 32'h0);
		wb(1'b0, vfdph_pkg::OFS_TXDATA, 32'h0, r);
		check(r, 32'h0000_00C3);
		// a lone nibble leaves the phase at lower, the next strobe completes the byte
		if (n) begin
			host.beat(1'b0, 1'b1, 8'h70, g);
			wb(1'b0, vfdph_pkg::OFS_STATUS, 32'h0, r);
			check(r, md | 32'h0000_0040);
			host.beat(1'b0, 1'b1, 8'h8F, g);
			wb(1'b0, vfdph_pkg::OFS_RXDATA, 32'h0, r);
			check(r, 32'h0000_0078);
		end
		$display("mode sep=%0d nibble=%0d done", s, n);
	endtask : run_mode
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		run_mode(1'b0, 1'b0);
		run_mode(1'b1, 1'b0);
		run_mode(1'b0, 1'b1);
		run_mode(1'b1, 1'b1);
		wrap_up();
	end
	// the whole run needs about 510 clocks; this leaves a wide margin
	initial begin
		#200us;
		bad_count++;
		wrap_up();
	end
endmodule : vfd_parallel_host_port_bench
